// *** rtl/tdmac_ctrl.v ***
// two-channel transfer controller: flow-through data mover between local and backplane
//
// Summary of operation
// - two independent channels, local 16-bit to 16/18/22-bit backplane address
// - local word or byte transfers; backplane always full word
// - chain loads channel parameters from memory table after start-chain command
// - runs alone and raises an interrupt at terminal count or on backplane init
// - source data compared with pattern under mask; match or mismatch flagged
// - one transfer per turn, channel A always first when pending; burst mode runs several transfers, re-requesting mastership for each cycle
// - source read into holding register, then written to destination
// - slave access by chip select, write line, strobes and byte/word line
// - selector outputs all lows on internal register access
// - mastership requested once parameters loaded
// - as master drives address strobe, then data strobe together with write line
// - end-of-pass from glue logic ends transfer and drops mastership request
// - backplane transfer first takes local bus, then raises backplane request
// - io page select asserted for addresses in top 4K of the 22-bit space
// - upper address bits driven on extended lines 16-21
// - backplane completion drops backplane request and mastership request
// - three hardware request sources, tx and counter jumper routable, individually maskable
// - transfers run to terminal count, or to end-of-pass outside the wait state, which stops active channel
// - backplane init makes controller give the local bus back
// - backplane halt does not stop the controller
`timescale 1ns/1ps
`default_nettype none
`include "tdmac_map.vh"

module tdmac_ctrl (
  input  wire        SYS_CLK_I,
  input  wire        RST_I,
  input  wire        CONTROLLER_CHIP_SELECT_N_I,
  input  wire        LOCAL_WRITE_N_I,
  output wire        LOCAL_WRITE_N_O,
  output wire        LOCAL_WRITE_N_OE_O,
  input  wire        LOCAL_ADDR_STROBE_N_I,
  output reg         LOCAL_ADDR_STROBE_N_O,
  output wire        LOCAL_ADDR_STROBE_N_OE_O,
  input  wire        LOCAL_DATA_STROBE_N_I,
  output reg         LOCAL_DATA_STROBE_N_O,
  output wire        LOCAL_DATA_STROBE_N_OE_O,
  input  wire        BYTE_WORD_SELECT_N_I,
  output reg         BYTE_WORD_SELECT_N_O,
  input  wire        VECTOR_ACK_N_I,
  input  wire        MEMORY_GRANT_N_I,
  output reg         MASTERSHIP_REQUEST_N_O,
  input  wire        PASS_END_N_I,
  input  wire        BACKPLANE_INIT_I,
  input  wire        BACKPLANE_HALT_N_I,
  input  wire [15:0] LOCAL_ADDR_DATA_BUS_I,
  output reg  [15:0] LOCAL_ADDR_DATA_BUS_O,
  output reg         LOCAL_ADDR_DATA_BUS_OE_O,
  output reg         BACKPLANE_REQUEST_O,
  output reg         IO_PAGE_SELECT_O,
  output reg  [5:0]  EXTENDED_ADDR_LINES_O,
  output wire [1:0]  EXT_CTRL_SELECT_O,
  input  wire        SERIAL_TX_DMA_REQ_N_I,
  input  wire        SERIAL_RX_DMA_REQ_N_I,
  input  wire        COUNTER_TIMER_DMA_REQ_N_I,
  input  wire        TX_REQ_TO_CHAN_A_I,
  input  wire        CT_REQ_TO_CHAN_A_I,
  output reg         INTERRUPT_O,
  output reg  [1:0]  PATTERN_EVENT_O
);

  // ----------------------------------------------------------------
  // states and storage
  // ----------------------------------------------------------------
  localparam ST_IDLE   = 3'd0;
  localparam ST_REQ    = 3'd1;
  localparam ST_BPREQ  = 3'd2;
  localparam ST_ADDR   = 3'd3;
  localparam ST_DATA   = 3'd4;
  localparam ST_WAIT   = 3'd5;
  localparam ST_NEXT   = 3'd6;
  localparam ST_RETURN = 3'd7;

  reg [2:0]  state;
  reg        phase_write;
  reg        chaining;
  reg [2:0]  chain_idx;
  reg        cur_ch;
  reg [15:0] hold;
  reg [3:0]  burst_left;
  reg [15:0] regs [0:1][0:11];
  reg [1:0]  active;
  reg [15:0] rd_data;
  reg        bp_phase;
  reg [21:0] cur_addr;
  reg [4:0]  slave_addr;
  wire [1:0] hw_req;
  wire [1:0] pend;
  wire       slave_sel;
  wire       sel_ch;
  wire [3:0] sel_reg;
  wire [15:0] mode_cur;

  function [21:0] full_addr;
    input [15:0] lo;
    input [15:0] hi;
    input [1:0]  bits;
    begin
      case (bits)
        2'd1:    full_addr = {4'h0, hi[1:0], lo};
        2'd2:    full_addr = {hi[5:0], lo};
        default: full_addr = {6'h00, lo};
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // request sources
  // ----------------------------------------------------------------
  // jumpers pick the channel for tx and counter requests; rx always to B
  assign hw_req[0] = ((TX_REQ_TO_CHAN_A_I & ~SERIAL_TX_DMA_REQ_N_I & ~regs[0][7][12])
                     | (CT_REQ_TO_CHAN_A_I & ~COUNTER_TIMER_DMA_REQ_N_I
                        & ~regs[0][7][14]));
  assign hw_req[1] = ((~TX_REQ_TO_CHAN_A_I & ~SERIAL_TX_DMA_REQ_N_I & ~regs[1][7][12])
                     | (~SERIAL_RX_DMA_REQ_N_I & ~regs[1][7][13])
                     | (~CT_REQ_TO_CHAN_A_I & ~COUNTER_TIMER_DMA_REQ_N_I
                        & ~regs[1][7][14]));
  assign pend[0] = active[0] & (~regs[0][7][`TDMAC_MODE_HWREQ] | hw_req[0]);
  assign pend[1] = active[1] & (~regs[1][7][`TDMAC_MODE_HWREQ] | hw_req[1]);

  assign slave_sel = ~CONTROLLER_CHIP_SELECT_N_I & (state == ST_IDLE);
  // bus carries address then data, so the register number is kept from the address strobe
  assign sel_ch    = slave_addr[4];
  assign sel_reg   = slave_addr[3:0];
  assign mode_cur  = regs[cur_ch][7];

  // internal access when neither vector ack nor grant
  assign EXT_CTRL_SELECT_O = {~VECTOR_ACK_N_I, ~MEMORY_GRANT_N_I};

  // strobes are driven only while granted and we own the bus
  assign LOCAL_ADDR_STROBE_N_OE_O = ~MASTERSHIP_REQUEST_N_O & ~MEMORY_GRANT_N_I;
  assign LOCAL_DATA_STROBE_N_OE_O = LOCAL_ADDR_STROBE_N_OE_O;
  assign LOCAL_WRITE_N_OE_O       = LOCAL_ADDR_STROBE_N_OE_O;
  assign LOCAL_WRITE_N_O = ~(phase_write & ~LOCAL_DATA_STROBE_N_O);

  always @* begin
    rd_data = regs[sel_ch][sel_reg];
    if (sel_reg == `TDMAC_REG_STATUS)
      rd_data = {14'h0000, active};
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  integer i;
  always @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      state <= ST_IDLE;
      phase_write <= 1'b0;
      chaining <= 1'b0;
      chain_idx <= 3'd0;
      cur_ch <= 1'b0;
      hold <= 16'h0000;
      burst_left <= 4'h0;
      active <= 2'b00;
      bp_phase <= 1'b0;
      cur_addr <= 22'h000000;
      slave_addr <= 5'h00;
      for (i = 0; i < 12; i = i + 1) begin
        regs[0][i] <= 16'h0000;
        regs[1][i] <= 16'h0000;
      end
      MASTERSHIP_REQUEST_N_O <= 1'b1;
      LOCAL_ADDR_STROBE_N_O <= 1'b1;
      LOCAL_DATA_STROBE_N_O <= 1'b1;
      BYTE_WORD_SELECT_N_O <= 1'b1;
      LOCAL_ADDR_DATA_BUS_O <= 16'h0000;
      LOCAL_ADDR_DATA_BUS_OE_O <= 1'b0;
      BACKPLANE_REQUEST_O <= 1'b0;
      IO_PAGE_SELECT_O <= 1'b0;
      EXTENDED_ADDR_LINES_O <= 6'h00;
      INTERRUPT_O <= 1'b0;
      PATTERN_EVENT_O <= 2'b00;
    end else begin
      INTERRUPT_O <= 1'b0;
      PATTERN_EVENT_O <= 2'b00;
      LOCAL_ADDR_DATA_BUS_OE_O <= 1'b0;
      if (slave_sel & ~LOCAL_ADDR_STROBE_N_I)
        slave_addr <= LOCAL_ADDR_DATA_BUS_I[4:0];
      if (slave_sel & ~LOCAL_DATA_STROBE_N_I & LOCAL_WRITE_N_I) begin
        LOCAL_ADDR_DATA_BUS_O <= rd_data;
        LOCAL_ADDR_DATA_BUS_OE_O <= 1'b1;
      end
      case (state)
        ST_IDLE: begin
          if (slave_sel & ~LOCAL_DATA_STROBE_N_I & ~LOCAL_WRITE_N_I) begin
            if (sel_reg == `TDMAC_REG_CMD) begin
              if (LOCAL_ADDR_DATA_BUS_I == `TDMAC_CMD_START)
                active[sel_ch] <= 1'b1;
              else if (LOCAL_ADDR_DATA_BUS_I == `TDMAC_CMD_CHAIN) begin
                chaining <= 1'b1;
                phase_write <= 1'b0;
                chain_idx <= 3'd0;
                cur_ch <= sel_ch;
                MASTERSHIP_REQUEST_N_O <= 1'b0;
                state <= ST_REQ;
              end else if (LOCAL_ADDR_DATA_BUS_I == `TDMAC_CMD_STOP)
                active[sel_ch] <= 1'b0;
            end else if (BYTE_WORD_SELECT_N_I)
              regs[sel_ch][sel_reg] <= LOCAL_ADDR_DATA_BUS_I; // word access only
          end else if (pend[0] | pend[1]) begin
            cur_ch <= ~pend[0];
            phase_write <= 1'b0;
            burst_left <= regs[~pend[0]][7][13:10];
            MASTERSHIP_REQUEST_N_O <= 1'b0;
            state <= ST_REQ;
          end
        end
        ST_REQ: begin
          if (~MEMORY_GRANT_N_I) begin
            if (chaining)
              cur_addr <= {6'h00, regs[cur_ch][`TDMAC_REG_CHAIN] + {12'h000, chain_idx, 1'b0}};
            else if (phase_write)
              cur_addr <= full_addr(regs[cur_ch][4], regs[cur_ch][5], mode_cur[9:8]);
            else
              cur_addr <= full_addr(regs[cur_ch][2], regs[cur_ch][3], mode_cur[9:8]);
            bp_phase <= ~chaining & (phase_write ? mode_cur[`TDMAC_MODE_DST_BP]
                                                 : mode_cur[`TDMAC_MODE_SRC_BP]);
            state <= ST_BPREQ;
          end
        end
        ST_BPREQ: begin
          BACKPLANE_REQUEST_O <= bp_phase;
          IO_PAGE_SELECT_O <= bp_phase & (cur_addr >= `TDMAC_IOPAGE_BASE);
          EXTENDED_ADDR_LINES_O <= bp_phase ? cur_addr[21:16] : 6'h00;
          // backplane: only full words; local may be a byte
          BYTE_WORD_SELECT_N_O <= ~(~bp_phase & ~chaining & mode_cur[`TDMAC_MODE_BYTE]);
          LOCAL_ADDR_DATA_BUS_O <= {cur_addr[15:1],
                                    ~bp_phase & mode_cur[`TDMAC_MODE_BYTE]
                                    & mode_cur[`TDMAC_MODE_UPPER]};
          LOCAL_ADDR_DATA_BUS_OE_O <= 1'b1;
          state <= ST_ADDR;
        end
        ST_ADDR: begin
          LOCAL_ADDR_STROBE_N_O <= 1'b0;
          LOCAL_ADDR_DATA_BUS_OE_O <= 1'b1;
          state <= ST_DATA;
        end
        ST_DATA: begin
          if (phase_write) begin
            LOCAL_ADDR_DATA_BUS_O <= hold;
            LOCAL_ADDR_DATA_BUS_OE_O <= 1'b1;
          end
          LOCAL_DATA_STROBE_N_O <= 1'b0;
          state <= ST_WAIT;
        end
        ST_WAIT: begin
          // completion of the cycle is marked by end-of-pass; halt is ignored here
          if (phase_write)
            LOCAL_ADDR_DATA_BUS_OE_O <= 1'b1;
          if (~PASS_END_N_I | BACKPLANE_INIT_I) begin
            LOCAL_ADDR_STROBE_N_O <= 1'b1;
            LOCAL_DATA_STROBE_N_O <= 1'b1;
            BACKPLANE_REQUEST_O <= 1'b0;
            IO_PAGE_SELECT_O <= 1'b0;
            MASTERSHIP_REQUEST_N_O <= 1'b1;
            if (BACKPLANE_INIT_I) begin
              active[cur_ch] <= 1'b0;
              chaining <= 1'b0;
              INTERRUPT_O <= 1'b1;
              state <= ST_RETURN;
            end else begin
              if (chaining)
                regs[cur_ch][3'd2 + chain_idx] <= LOCAL_ADDR_DATA_BUS_I;
              else if (~phase_write) begin
                hold <= LOCAL_ADDR_DATA_BUS_I;
                if (((LOCAL_ADDR_DATA_BUS_I ^ regs[cur_ch][8]) & ~regs[cur_ch][9]) == 16'h0)
                  PATTERN_EVENT_O <= {1'b0, mode_cur[`TDMAC_MODE_MATCH_ON]};
                else
                  PATTERN_EVENT_O <= {mode_cur[`TDMAC_MODE_MISMATCH], 1'b0};
              end
              state <= ST_NEXT;
            end
          end
        end
        ST_NEXT: begin
          if (chaining) begin
            if (chain_idx == `TDMAC_CHAIN_WORDS - 3'd1) begin
              chaining <= 1'b0;
              active[cur_ch] <= 1'b1;
              state <= ST_RETURN;
            end else begin
              chain_idx <= chain_idx + 3'd1;
              MASTERSHIP_REQUEST_N_O <= 1'b0;
              state <= ST_REQ;
            end
          end else if (~phase_write) begin
            phase_write <= 1'b1;
            MASTERSHIP_REQUEST_N_O <= 1'b0;
            state <= ST_REQ;
          end else begin
            phase_write <= 1'b0;
            regs[cur_ch][2] <= regs[cur_ch][2] + 16'h0002;
            regs[cur_ch][4] <= regs[cur_ch][4] + 16'h0002;
            regs[cur_ch][6] <= regs[cur_ch][6] - 16'h0001;
            if (regs[cur_ch][6] == 16'h0001) begin
              active[cur_ch] <= 1'b0;
              INTERRUPT_O <= 1'b1;
              state <= ST_RETURN;
            end else if (mode_cur[`TDMAC_MODE_BURST] & (burst_left != 4'h0)) begin
              burst_left <= burst_left - 4'h1;
              MASTERSHIP_REQUEST_N_O <= 1'b0;
              state <= ST_REQ;
            end else
              state <= ST_RETURN;
          end
        end
        ST_RETURN: begin
          if (MEMORY_GRANT_N_I & ~BACKPLANE_INIT_I)
            state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
      // end-of-pass outside the wait state stops the active channel, except in idle or while chaining
      if (~PASS_END_N_I & (state != ST_WAIT) & (state != ST_IDLE) & ~chaining) begin
        active[cur_ch] <= 1'b0;
      end
      // init may land in any owned state; waiting for the data phase holds the bus too long
      if (BACKPLANE_INIT_I & ~MASTERSHIP_REQUEST_N_O) begin
        LOCAL_ADDR_STROBE_N_O <= 1'b1;
        LOCAL_DATA_STROBE_N_O <= 1'b1;
        LOCAL_ADDR_DATA_BUS_OE_O <= 1'b0;
        BACKPLANE_REQUEST_O <= 1'b0;
        IO_PAGE_SELECT_O <= 1'b0;
        MASTERSHIP_REQUEST_N_O <= 1'b1;
        active[cur_ch] <= 1'b0;
        chaining <= 1'b0;
        phase_write <= 1'b0;
        INTERRUPT_O <= 1'b1;
        state <= ST_RETURN;
      end
    end
  end

endmodule
`default_nettype wire

// *** rtl/tdmac_map.vh ***
// constants for the two-channel transfer controller
`ifndef TDMAC_MAP_VH
`define TDMAC_MAP_VH
`define TDMAC_REG_ADDR      4'h0
`define TDMAC_REG_CHAIN     4'h1
`define TDMAC_REG_SRC_LO    4'h2
`define TDMAC_REG_SRC_HI    4'h3
`define TDMAC_REG_DST_LO    4'h4
`define TDMAC_REG_DST_HI    4'h5
`define TDMAC_REG_COUNT     4'h6
`define TDMAC_REG_MODE      4'h7
`define TDMAC_REG_PATTERN   4'h8
`define TDMAC_REG_MASK      4'h9
`define TDMAC_REG_CMD       4'ha
`define TDMAC_REG_STATUS    4'hb
`define TDMAC_CMD_START     16'h0001
`define TDMAC_CMD_CHAIN     16'h0002
`define TDMAC_CMD_STOP      16'h0003
`define TDMAC_CHAIN_WORDS   3'd6
`define TDMAC_IOPAGE_BASE   22'h3ff000
`define TDMAC_MODE_SRC_BP   0
`define TDMAC_MODE_DST_BP   1
`define TDMAC_MODE_BYTE     2
`define TDMAC_MODE_UPPER    3
`define TDMAC_MODE_HWREQ    4
`define TDMAC_MODE_BURST    5
`define TDMAC_MODE_MATCH_ON 6
`define TDMAC_MODE_MISMATCH 7
`define TDMAC_MODE_ABITS0   8
`define TDMAC_MODE_BURST0   10
`define TDMAC_MODE_REQMASK0 12
`endif

// *** verif/tdmac_checker_assertions.sv ***
// concurrent checks on the transfer controller top ports
`timescale 1ns/1ps
`default_nettype none
module tdmac_checker (
  input wire logic       SYS_CLK_I,
  input wire logic       RST_I,
  input wire logic       VECTOR_ACK_N_I,
  input wire logic       MEMORY_GRANT_N_I,
  input wire logic       PASS_END_N_I,
  input wire logic       BACKPLANE_INIT_I,
  input wire logic       MASTERSHIP_REQUEST_N_O,
  input wire logic       LOCAL_ADDR_STROBE_N_O,
  input wire logic       LOCAL_ADDR_STROBE_N_OE_O,
  input wire logic       LOCAL_DATA_STROBE_N_O,
  input wire logic       LOCAL_WRITE_N_O,
  input wire logic       LOCAL_WRITE_N_OE_O,
  input wire logic       BACKPLANE_REQUEST_O,
  input wire logic       IO_PAGE_SELECT_O,
  input wire logic [1:0] EXT_CTRL_SELECT_O,
  input wire logic       INTERRUPT_O,
  input wire logic [1:0] PATTERN_EVENT_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  // ----------------------------------------------------------------
  // local bus ownership
  // ----------------------------------------------------------------
  ext_sel_a: assert property (EXT_CTRL_SELECT_O == {~VECTOR_ACK_N_I, ~MEMORY_GRANT_N_I})
    else $error("selector does not follow ack and grant");
  master_oe_a: assert property (LOCAL_ADDR_STROBE_N_OE_O |-> !MEMORY_GRANT_N_I && !MASTERSHIP_REQUEST_N_O)
    else $error("strobes driven without grant");
  as_first_a: assert property ($fell(LOCAL_DATA_STROBE_N_O) |-> !$past(LOCAL_ADDR_STROBE_N_O) || !$past(LOCAL_ADDR_STROBE_N_O, 2))
    else $error("data strobe without address strobe first");
  wr_in_ds_a: assert property (LOCAL_WRITE_N_OE_O && !LOCAL_WRITE_N_O |-> !LOCAL_DATA_STROBE_N_O)
    else $error("write line low outside data strobe");
  eop_end_a: assert property (!PASS_END_N_I && !LOCAL_DATA_STROBE_N_O |-> ##[1:2] (LOCAL_DATA_STROBE_N_O && MASTERSHIP_REQUEST_N_O))
    else $error("pass end did not release strobe and request");
  // ----------------------------------------------------------------
  // backplane side
  // ----------------------------------------------------------------
  bp_needs_local_a: assert property (BACKPLANE_REQUEST_O |-> !MASTERSHIP_REQUEST_N_O)
    else $error("backplane request without local request");
  bp_release_a: assert property ($fell(BACKPLANE_REQUEST_O) |-> ##[0:1] MASTERSHIP_REQUEST_N_O)
    else $error("local request held after backplane end");
  iop_in_bp_a: assert property (IO_PAGE_SELECT_O |-> BACKPLANE_REQUEST_O)
    else $error("io page select outside backplane cycle");
  init_release_a: assert property (BACKPLANE_INIT_I && !MASTERSHIP_REQUEST_N_O |-> ##[1:2] MASTERSHIP_REQUEST_N_O)
    else $error("local bus kept during backplane init");
  // ----------------------------------------------------------------
  // events
  // ----------------------------------------------------------------
  irq_pulse_a: assert property (INTERRUPT_O |=> !INTERRUPT_O)
    else $error("interrupt longer than one cycle");
  pattern_one_a: assert property (PATTERN_EVENT_O != 2'b11)
    else $error("match and mismatch together");
  reset_idle_a: assert property (@(posedge SYS_CLK_I) disable iff (1'b0) RST_I |=> MASTERSHIP_REQUEST_N_O && !BACKPLANE_REQUEST_O && !INTERRUPT_O)
    else $error("outputs active after reset");
endmodule
`default_nettype wire

// *** verif/tdmac_glue_model.sv ***
// processor grant, glue pass end and word memory behind the local bus
`timescale 1ns/1ps
`default_nettype none
module tdmac_glue_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        req_n_i,
  input  wire logic        cs_n_i,
  input  wire logic        abort_i,
  input  wire logic        as_n_i,
  input  wire logic        ds_n_i,
  input  wire logic        wr_n_i,
  input  wire logic        oe_i,
  input  wire logic        bp_i,
  input  wire logic [15:0] bus_i,
  input  wire logic [3:0]  slow_i,
  output logic             grant_n_o,
  output logic             eop_n_o,
  output logic             rd_oe_o,
  output logic [15:0]      rd_data_o
);
  logic [15:0] mem [0:255];
  logic [7:0]  idx;
  logic [3:0]  wait_cnt;
  logic [7:0]  tmo_cnt;
  // backplane words sit in the upper half, so both spaces stay apart
  always @(posedge clk_i) begin
    if (rst_i) begin
      grant_n_o <= 1'b1;
      eop_n_o <= 1'b1;
      wait_cnt <= 4'h0;
      tmo_cnt <= 8'h00;
    end else begin
      grant_n_o <= req_n_i;
      eop_n_o <= 1'b1;
      if (oe_i && !as_n_i && ds_n_i) idx <= {bp_i, bus_i[7:1]};
      if (ds_n_i) tmo_cnt <= 8'h00;
      if (oe_i && !ds_n_i && eop_n_o) begin
        wait_cnt <= wait_cnt + 4'h1;
        tmo_cnt <= tmo_cnt + 8'h01;
        if (wait_cnt >= slow_i) begin
          eop_n_o <= 1'b0;
          wait_cnt <= 4'h0;
          if (!wr_n_i) mem[idx] <= bus_i;
        end
        // cut passes: the cycle ends with nothing written
        if (!cs_n_i) eop_n_o <= 1'b0;
        if (bp_i && abort_i) eop_n_o <= 1'b0;
        // 200 cycles of 50 ns make the 10 us reply limit
        if (bp_i && tmo_cnt == 8'hc7) eop_n_o <= 1'b0;
      end
    end
  end
  assign rd_oe_o = oe_i && !ds_n_i && wr_n_i;
  assign rd_data_o = mem[idx];
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
// self-checking bench for the two-channel transfer controller
`timescale 1ns/1ps
`default_nettype none
`include "tdmac_map.vh"
module tb_top;
  logic clk = 1'b0, rst = 1'b1, cs_n = 1'b1, wr_n = 1'b1, as_n = 1'b1, ds_n = 1'b1;
  logic init = 1'b0, vack_n = 1'b1, tx_n = 1'b1, rx_n = 1'b1, ct_n = 1'b1, bw_n = 1'b1;
  logic saw_bp, saw_iop, saw_match, saw_irq, saw_miss;
  logic clr_seen = 1'b0, halt_n = 1'b1;
  logic [15:0] tb_bus = 16'hffff, rd;
  logic [5:0]  last_ext;
  logic [3:0]  slow = 4'h0;
  int          err_count = 0, tests_run = 0, cycles = 0;
  wire  wr_o, wr_oe, as_o, as_oe, ds_o, ds_oe, bw_o, req_n, bus_oe, bpreq, iop, irq;
  wire  grant_n, eop_n, mem_oe;
  wire  [15:0] bus_o, mem_d;
  wire  [5:0]  ext;
  wire  [1:0]  sel, pev;
  // shared wires: whoever enables drives, else the processor side
  wire  as_w = as_oe ? as_o : as_n;
  wire  ds_w = ds_oe ? ds_o : ds_n;
  wire  wr_w = wr_oe ? wr_o : wr_n;
  wire  [15:0] bus_w = bus_oe ? bus_o : (mem_oe ? mem_d : tb_bus);
  always #25 clk = ~clk;
  tdmac_ctrl tdmac_ctrl_i (.SYS_CLK_I(clk), .RST_I(rst), .CONTROLLER_CHIP_SELECT_N_I(cs_n),
    .LOCAL_WRITE_N_I(wr_w), .LOCAL_WRITE_N_O(wr_o), .LOCAL_WRITE_N_OE_O(wr_oe),
    .LOCAL_ADDR_STROBE_N_I(as_w), .LOCAL_ADDR_STROBE_N_O(as_o), .LOCAL_ADDR_STROBE_N_OE_O(as_oe),
    .LOCAL_DATA_STROBE_N_I(ds_w), .LOCAL_DATA_STROBE_N_O(ds_o), .LOCAL_DATA_STROBE_N_OE_O(ds_oe),
    .BYTE_WORD_SELECT_N_I(bw_n), .BYTE_WORD_SELECT_N_O(bw_o), .VECTOR_ACK_N_I(vack_n),
    .MEMORY_GRANT_N_I(grant_n), .MASTERSHIP_REQUEST_N_O(req_n), .PASS_END_N_I(eop_n),
    .BACKPLANE_INIT_I(init), .BACKPLANE_HALT_N_I(halt_n), .LOCAL_ADDR_DATA_BUS_I(bus_w),
    .LOCAL_ADDR_DATA_BUS_O(bus_o), .LOCAL_ADDR_DATA_BUS_OE_O(bus_oe), .BACKPLANE_REQUEST_O(bpreq),
    .IO_PAGE_SELECT_O(iop), .EXTENDED_ADDR_LINES_O(ext), .EXT_CTRL_SELECT_O(sel),
    .SERIAL_TX_DMA_REQ_N_I(tx_n), .SERIAL_RX_DMA_REQ_N_I(rx_n), .COUNTER_TIMER_DMA_REQ_N_I(ct_n),
    .TX_REQ_TO_CHAN_A_I(1'b1), .CT_REQ_TO_CHAN_A_I(1'b1), .INTERRUPT_O(irq), .PATTERN_EVENT_O(pev));
  tdmac_glue_model tdmac_glue_model_i (.clk_i(clk), .rst_i(rst), .req_n_i(req_n), .as_n_i(as_w),
    .cs_n_i(cs_n), .abort_i(1'b0),
    .ds_n_i(ds_w), .wr_n_i(wr_w), .oe_i(ds_oe), .bp_i(bpreq), .bus_i(bus_w), .slow_i(slow),
    .grant_n_o(grant_n), .eop_n_o(eop_n), .rd_oe_o(mem_oe), .rd_data_o(mem_d));
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // ----------------------------------------------------------------
  // slave access: address phase, then data phase
  // ----------------------------------------------------------------
  task automatic wr_reg(input logic ch, input logic [3:0] rg, input logic [15:0] d);
    @(posedge clk); cs_n <= 1'b0; as_n <= 1'b0; tb_bus <= {11'h0, ch, rg};
    @(posedge clk); as_n <= 1'b1; ds_n <= 1'b0; wr_n <= 1'b0; tb_bus <= d;
    @(posedge clk); check("selector", {30'h0, sel}, 32'h0);
    cs_n <= 1'b1; ds_n <= 1'b1; wr_n <= 1'b1; tb_bus <= ~d;
  endtask
  task automatic rd_reg(input logic ch, input logic [3:0] rg);
    @(posedge clk); cs_n <= 1'b0; as_n <= 1'b0; tb_bus <= {11'h0, ch, rg};
    @(posedge clk); as_n <= 1'b1; ds_n <= 1'b0; tb_bus <= 16'h5a5a;
    @(posedge clk);
    @(posedge clk); #1 rd = bus_oe ? bus_o : 16'hxxxx;
    @(posedge clk); cs_n <= 1'b1; ds_n <= 1'b1; tb_bus <= 16'ha5a5;
  endtask
  task automatic run(input logic ch, input logic [15:0] dlo, dhi, cnt, mode, input logic [3:0] s);
    slow <= s;
    clr_seen <= 1'b1;
    wr_reg(ch, `TDMAC_REG_SRC_LO, 16'h0040);
    clr_seen <= 1'b0;
    wr_reg(ch, `TDMAC_REG_SRC_HI, 16'h0000);
    wr_reg(ch, `TDMAC_REG_DST_LO, dlo); wr_reg(ch, `TDMAC_REG_DST_HI, dhi);
    wr_reg(ch, `TDMAC_REG_COUNT, cnt); wr_reg(ch, `TDMAC_REG_MODE, mode);
    wr_reg(ch, `TDMAC_REG_PATTERN, 16'h1234); wr_reg(ch, `TDMAC_REG_MASK, 16'h0000);
    wr_reg(ch, `TDMAC_REG_CMD, `TDMAC_CMD_START);
  endtask
  task automatic wait_irq();
    for (int i = 0; i < 3000 && !saw_irq; i++) @(posedge clk);
    check("interrupt", {31'h0, saw_irq}, 32'h1);
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (bpreq) last_ext <= ext;
    if (clr_seen) begin
      saw_bp <= 1'b0;
      saw_iop <= 1'b0;
      saw_match <= 1'b0;
      saw_miss <= 1'b0;
      saw_irq <= 1'b0;
    end else begin
      if (bpreq) saw_bp <= 1'b1;
      if (iop) saw_iop <= 1'b1;
      if (pev[0]) saw_match <= 1'b1;
      if (pev[1]) saw_miss <= 1'b1;
      if (irq) saw_irq <= 1'b1;
    end
    if (cycles == 30000) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    tdmac_glue_model_i.mem[8'h20] = 16'h1234;
    tdmac_glue_model_i.mem[8'h21] = 16'habcd;
    // chain table at local 0x0060: src lo/hi, dst lo/hi, count, mode
    tdmac_glue_model_i.mem[8'h30] = 16'h0040;
    tdmac_glue_model_i.mem[8'h31] = 16'h0000;
    tdmac_glue_model_i.mem[8'h32] = 16'h00a0;
    tdmac_glue_model_i.mem[8'h33] = 16'h0000;
    tdmac_glue_model_i.mem[8'h34] = 16'h0001;
    tdmac_glue_model_i.mem[8'h35] = 16'h0080;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk); #1;
    check("request idle", {31'h0, req_n}, 32'h1);
    rd_reg(1'b0, `TDMAC_REG_STATUS);
    check("status idle", {16'h0, rd}, 32'h0);
    $display("test idle done");
    // two local words with pattern notify
    run(1'b0, 16'h0080, 16'h0000, 16'h0002, 16'h0040, 4'h0);
    wait_irq();
    check("word 0", {16'h0, tdmac_glue_model_i.mem[8'h40]}, 32'h1234);
    check("word 1", {16'h0, tdmac_glue_model_i.mem[8'h41]}, 32'habcd);
    check("match", {31'h0, saw_match}, 32'h1);
    check("no backplane", {31'h0, saw_bp}, 32'h0);
    $display("test local done");
    // one word to a 22-bit io page address, slow replies
    run(1'b1, 16'hf000, 16'h003f, 16'h0001, 16'h0202, 4'h3);
    halt_n <= 1'b0;
    wait_irq();
    halt_n <= 1'b1;
    check("backplane", {31'h0, saw_bp}, 32'h1);
    check("io page", {31'h0, saw_iop}, 32'h1);
    check("upper lines", {26'h0, last_ext}, 32'h3f);
    check("bp word", {16'h0, tdmac_glue_model_i.mem[8'h80]}, 32'h1234);
    $display("test backplane done");
    // backplane init while the controller owns the local bus
    run(1'b0, 16'h00c0, 16'h0000, 16'h0002, 16'h0000, 4'hf);
    for (int i = 0; i < 200 && (req_n || grant_n); i++) @(posedge clk);
    init <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check("bus returned", {31'h0, req_n}, 32'h1);
    @(posedge clk); init <= 1'b0;
    repeat (20) @(posedge clk);
    $display("test init done");
    // chained parameter load, then one word with mismatch notify
    slow <= 4'h0;
    clr_seen <= 1'b1;
    wr_reg(1'b0, `TDMAC_REG_PATTERN, 16'h0000);
    clr_seen <= 1'b0;
    wr_reg(1'b0, `TDMAC_REG_CHAIN, 16'h0060);
    wr_reg(1'b0, `TDMAC_REG_CMD, `TDMAC_CMD_CHAIN);
    wait_irq();
    check("chain word", {16'h0, tdmac_glue_model_i.mem[8'h50]}, 32'h1234);
    check("mismatch", {31'h0, saw_miss}, 32'h1);
    check("no match", {31'h0, saw_match}, 32'h0);
    $display("test chain done");
    complete_run();
  end
endmodule
bind tdmac_ctrl tdmac_checker tdmac_checker_i (
  .SYS_CLK_I(SYS_CLK_I),
  .RST_I(RST_I),
  .VECTOR_ACK_N_I(VECTOR_ACK_N_I),
  .MEMORY_GRANT_N_I(MEMORY_GRANT_N_I),
  .PASS_END_N_I(PASS_END_N_I),
  .BACKPLANE_INIT_I(BACKPLANE_INIT_I),
  .MASTERSHIP_REQUEST_N_O(MASTERSHIP_REQUEST_N_O),
  .LOCAL_ADDR_STROBE_N_O(LOCAL_ADDR_STROBE_N_O),
  .LOCAL_ADDR_STROBE_N_OE_O(LOCAL_ADDR_STROBE_N_OE_O),
  .LOCAL_DATA_STROBE_N_O(LOCAL_DATA_STROBE_N_O),
  .LOCAL_WRITE_N_O(LOCAL_WRITE_N_O),
  .LOCAL_WRITE_N_OE_O(LOCAL_WRITE_N_OE_O),
  .BACKPLANE_REQUEST_O(BACKPLANE_REQUEST_O),
  .IO_PAGE_SELECT_O(IO_PAGE_SELECT_O),
  .EXT_CTRL_SELECT_O(EXT_CTRL_SELECT_O),
  .INTERRUPT_O(INTERRUPT_O),
  .PATTERN_EVENT_O(PATTERN_EVENT_O)
);
`default_nettype wire
